// ---- design/aisb_pkg.sv ----
package aisb_pkg;
  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_KEYPAD_PIN_ENABLE = 8'ha1;
  localparam logic [7:0] ADDR_AUX_FUNCTION_CTRL = 8'ha2;
  localparam logic [7:0] ADDR_IRQ_ENABLE_MASK   = 8'ha8;
  localparam logic [7:0] ADDR_SERIAL_NODE_ADDR  = 8'ha9;
  localparam logic [7:0] ADDR_COMP_ONE_CTRL     = 8'hac;
  localparam logic [7:0] ADDR_IRQ_SOURCE_STATUS = 8'hb0;

  // Aux function control fields
  localparam int AUX_KEYPAD_FLAG   = 7;
  localparam int AUX_BROWNOUT_OFF  = 6;
  localparam int AUX_BROWNOUT_IRQ  = 5;
  localparam int AUX_BROWNOUT_DUTY = 4;
  localparam int AUX_SOFT_RESET    = 3;
  localparam int AUX_ADC_POWER     = 2;
  localparam int AUX_POINTER_SEL   = 0;
  localparam logic [7:0] AUX_WRITE_MASK = 8'h75;

  // Interrupt enable fields
  localparam int IE_GLOBAL = 7;

  // Comparator one control fields
  localparam int CMP_ENABLE   = 5;
  localparam int CMP_POS_SEL  = 4;
  localparam int CMP_NEG_SEL  = 3;
  localparam int CMP_PIN_DRV  = 2;
  localparam int CMP_RESULT   = 1;
  localparam int CMP_FLAG     = 0;
  localparam logic [7:0] CMP_WRITE_MASK = 8'h3c;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Low power brownout duty: on one cycle in sixteen
  localparam int DUTY_PERIOD = 16;
  localparam int DUTY_WIDTH  = 4;

  // Soft reset pulse length in cycles
  localparam int SOFT_RESET_CYCLES = 1;
endpackage

// ---- design/aisb_sync2.sv ----
`timescale 1ns/1ps
// Two flop synchroniser for a bus of levels
module aisb_sync2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Reset value is a constant at the instance
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= rst_val_i;
      sync_q <= rst_val_i;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // aisb_sync2

// ---- design/aisb_bank.sv ----
`timescale 1ns/1ps
module aisb_bank (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Device side
  input  wire logic [7:0]  port0_pins_i,
  input  wire logic        comp_raw_i,
  input  wire logic        brownout_flag_i,
  input  wire logic        power_down_i,
  input  wire logic [6:0]  irq_sources_i,
  output logic             comp_enable_o,
  output logic             comp_pos_select_o,
  output logic             comp_neg_select_o,
  output logic             comp_pin_o,
  output logic             comp_pin_oe_n_o,
  output logic             comp_irq_o,
  output logic             keypad_irq_o,
  output logic             brownout_detect_on_o,
  output logic             brownout_irq_o,
  output logic             brownout_reset_o,
  output logic             rc_osc_enable_o,
  output logic             chip_reset_o,
  output logic             adc_power_on_o,
  output logic             pointer_select_o,
  output logic [7:0]       irq_enable_o,
  output logic [7:0]       serial_node_address_o
);
  localparam logic [7:0] PORT_IDLE = 8'hff;

  logic [7:0] keypad_pin_enable_q;
  logic [7:0] aux_q;
  logic [7:0] aux_d;
  logic [7:0] ie_q;
  logic [7:0] serial_node_address_q;
  logic [7:0] cmp_q;
  logic [7:0] cmp_d;
  logic       comp_sync_q;
  logic       comp_meta_q;
  logic       ack_q;
  logic       err_q;
  logic [31:0] rdata_q;
  logic [3:0] duty_q;
  logic       detect_on_q;
  logic       brown_rst_q;
  logic       brown_irq_q;
  logic       rc_on_q;
  logic       chip_rst_q;
  logic       comp_pin_q;
  logic       comp_oe_n_q;
  logic       comp_irq_q;
  logic       key_irq_q;
  logic [6:0] src_q;
  logic [7:0] port_sync;

  // Bus decode
  wire        req       = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  wire        lane0     = wb_sel_i[0];
  wire        wr        = req & wb_we_i & lane0;
  wire        hit_kpe   = wb_adr_i == aisb_pkg::ADDR_KEYPAD_PIN_ENABLE;
  wire        hit_aux   = wb_adr_i == aisb_pkg::ADDR_AUX_FUNCTION_CTRL;
  wire        hit_ie    = wb_adr_i == aisb_pkg::ADDR_IRQ_ENABLE_MASK;
  wire        hit_sad   = wb_adr_i == aisb_pkg::ADDR_SERIAL_NODE_ADDR;
  wire        hit_cmp   = wb_adr_i == aisb_pkg::ADDR_COMP_ONE_CTRL;
  wire        hit_src   = wb_adr_i == aisb_pkg::ADDR_IRQ_SOURCE_STATUS;
  wire        mapped    = hit_kpe | hit_aux | hit_ie | hit_sad | hit_cmp | hit_src;
  wire [7:0]  wbyte     = wb_dat_i[7:0];

  // Keypad detect on synchronised pins
  aisb_sync2 #(.WIDTH(8)) u_port_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .async_i   (port0_pins_i),
    .rst_val_i (PORT_IDLE),
    .sync_o    (port_sync)
  );
  wire        key_event = |(keypad_pin_enable_q & ~port_sync);

  // Comparator state
  wire        cmp_en     = cmp_q[aisb_pkg::CMP_ENABLE];
  wire        comp_res   = cmp_en & comp_sync_q;
  wire        comp_chg   = comp_res != cmp_q[aisb_pkg::CMP_RESULT];
  wire        cmp_wr     = wr & hit_cmp;
  wire        en_after   = cmp_wr ? wbyte[aisb_pkg::CMP_ENABLE] : cmp_en;
  wire        flag_clr   = cmp_wr & ~wbyte[aisb_pkg::CMP_FLAG];

  // Aux register next value; flag set wins over clear
  wire        aux_wr     = wr & hit_aux;
  wire        key_keep   = aux_wr ? wbyte[aisb_pkg::AUX_KEYPAD_FLAG]
                                  : aux_q[aisb_pkg::AUX_KEYPAD_FLAG];
  always_comb begin
    aux_d = aux_q;
    if (aux_wr) begin
      aux_d = (aux_q & ~aisb_pkg::AUX_WRITE_MASK) | (wbyte & aisb_pkg::AUX_WRITE_MASK);
    end
    aux_d[aisb_pkg::AUX_KEYPAD_FLAG] = key_event | key_keep;
    // Soft reset is self clearing
    aux_d[aisb_pkg::AUX_SOFT_RESET]  = aux_wr & wbyte[aisb_pkg::AUX_SOFT_RESET];
    aux_d[1] = 1'b0;
  end

  // Comparator register next value; change sets even as software clears
  always_comb begin
    cmp_d = cmp_q;
    if (cmp_wr) begin
      cmp_d = (cmp_q & ~aisb_pkg::CMP_WRITE_MASK) | (wbyte & aisb_pkg::CMP_WRITE_MASK);
    end
    cmp_d[aisb_pkg::CMP_RESULT] = comp_res;
    if (!en_after) begin
      cmp_d[aisb_pkg::CMP_FLAG]   = 1'b0;
      cmp_d[aisb_pkg::CMP_RESULT] = 1'b0;
    end else if (comp_chg) begin
      cmp_d[aisb_pkg::CMP_FLAG] = 1'b1;
    end else if (flag_clr) begin
      cmp_d[aisb_pkg::CMP_FLAG] = 1'b0;
    end
    cmp_d[7:6] = 2'b00;
  end

  // Read mux
  wire [7:0]  rbyte = hit_kpe ? keypad_pin_enable_q :
                      hit_aux ? aux_q :
                      hit_ie  ? ie_q :
                      hit_sad ? serial_node_address_q :
                      hit_cmp ? cmp_q :
                      hit_src ? {1'b0, src_q} : 8'h00;

  // Brownout and duty control
  wire        bo_on     = ~aux_q[aisb_pkg::AUX_BROWNOUT_OFF];
  wire        duty_mode = bo_on & aux_q[aisb_pkg::AUX_BROWNOUT_DUTY] & power_down_i;
  wire        duty_slot = duty_q == 4'h0;
  wire        det_next  = bo_on & (~duty_mode | duty_slot);
  wire        bo_hit    = bo_on & brownout_flag_i;
  wire        gate      = ie_q[aisb_pkg::IE_GLOBAL];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keypad_pin_enable_q <= aisb_pkg::RESET_BYTE;
      aux_q               <= aisb_pkg::RESET_BYTE;
      ie_q                <= aisb_pkg::RESET_BYTE;
      serial_node_address_q             <= aisb_pkg::RESET_BYTE;
      cmp_q               <= aisb_pkg::RESET_BYTE;
    end else begin
      if (wr && hit_kpe) keypad_pin_enable_q <= wbyte;
      if (wr && hit_ie)  ie_q                <= wbyte;
      if (wr && hit_sad) serial_node_address_q             <= wbyte;
      aux_q <= aux_d;
      cmp_q <= cmp_d;
    end
  end

  // Comparator raw input synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comp_raw_i;
      comp_sync_q <= comp_meta_q;
    end
  end

  // Bus answer: one cycle after request, error on unmapped address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= req & mapped;
      err_q   <= req & ~mapped;
      rdata_q <= (req & ~wb_we_i) ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_q <= 4'h0;
    end else begin
      duty_q <= duty_mode ? duty_q + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      detect_on_q <= 1'b0;
      brown_rst_q <= 1'b0;
      brown_irq_q <= 1'b0;
      rc_on_q     <= 1'b0;
      chip_rst_q  <= 1'b0;
      src_q       <= 7'h00;
      key_irq_q   <= 1'b0;
      comp_irq_q  <= 1'b0;
    end else begin
      detect_on_q <= det_next;
      brown_rst_q <= bo_hit & ~aux_q[aisb_pkg::AUX_BROWNOUT_IRQ];
      brown_irq_q <= gate & ie_q[5] & bo_hit & aux_q[aisb_pkg::AUX_BROWNOUT_IRQ];
      rc_on_q     <= duty_mode;
      chip_rst_q  <= aux_q[aisb_pkg::AUX_SOFT_RESET];
      src_q       <= {7{gate}} & ie_q[6:0] & irq_sources_i;
      key_irq_q   <= gate & aux_q[aisb_pkg::AUX_KEYPAD_FLAG];
      comp_irq_q  <= gate & cmp_q[aisb_pkg::CMP_FLAG];
    end
  end

  // Raw comparator path to the pin, unsynchronised by intent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_pin_q  <= 1'b0;
      comp_oe_n_q <= 1'b1;
    end else begin
      comp_pin_q  <= comp_raw_i;
      comp_oe_n_q <= ~(cmp_en & cmp_q[aisb_pkg::CMP_PIN_DRV]);
    end
  end

  assign wb_dat_o              = rdata_q;
  assign wb_ack_o              = ack_q;
  assign wb_err_o              = err_q;
  assign comp_enable_o         = cmp_en;
  assign comp_pos_select_o     = cmp_q[aisb_pkg::CMP_POS_SEL];
  assign comp_neg_select_o     = cmp_q[aisb_pkg::CMP_NEG_SEL];
  assign comp_pin_o            = comp_pin_q;
  assign comp_pin_oe_n_o       = comp_oe_n_q;
  assign comp_irq_o            = comp_irq_q;
  assign keypad_irq_o          = key_irq_q;
  assign brownout_detect_on_o  = detect_on_q;
  assign brownout_irq_o        = brown_irq_q;
  assign brownout_reset_o      = brown_rst_q;
  assign rc_osc_enable_o       = rc_on_q;
  assign chip_reset_o          = chip_rst_q;
  assign adc_power_on_o        = aux_q[aisb_pkg::AUX_ADC_POWER];
  assign pointer_select_o      = aux_q[aisb_pkg::AUX_POINTER_SEL];
  assign irq_enable_o          = ie_q;
  assign serial_node_address_o = serial_node_address_q;

  // Checks
  property p_key_set;
    @(posedge clk_i) disable iff (rst_i)
      key_event |=> aux_q[aisb_pkg::AUX_KEYPAD_FLAG];
  endproperty
  a_key_set: assert property (p_key_set) else $error("keypad flag not set");

  property p_key_hold;
    @(posedge clk_i) disable iff (rst_i)
      aux_q[aisb_pkg::AUX_KEYPAD_FLAG] && !aux_wr |=> aux_q[aisb_pkg::AUX_KEYPAD_FLAG];
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("keypad flag lost");

  property p_pin_to_flag;
    @(posedge clk_i) disable iff (rst_i)
      keypad_pin_enable_q[0] && !port0_pins_i[0] ##1 keypad_pin_enable_q[0] && !port0_pins_i[0]
      ##1 keypad_pin_enable_q[0] |=> aux_q[aisb_pkg::AUX_KEYPAD_FLAG];
  endproperty
  a_pin_to_flag: assert property (p_pin_to_flag) else $error("pin low missed");

  property p_soft_chip_reset;
    @(posedge clk_i) disable iff (rst_i)
      aux_wr && wbyte[aisb_pkg::AUX_SOFT_RESET] |=> ##1 chip_reset_o ##1 !chip_reset_o;
  endproperty
  a_soft_chip_reset: assert property (p_soft_chip_reset) else $error("soft reset pulse wrong");

  property p_cmp_off;
    @(posedge clk_i) disable iff (rst_i)
      !cmp_en |-> !cmp_q[aisb_pkg::CMP_RESULT] && !cmp_q[aisb_pkg::CMP_FLAG];
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("comparator bits not cleared");

  property p_cmp_flag;
    @(posedge clk_i) disable iff (rst_i)
      cmp_en && $changed(cmp_q[aisb_pkg::CMP_RESULT]) |-> cmp_q[aisb_pkg::CMP_FLAG];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("change flag missing");

  property p_gate;
    @(posedge clk_i) disable iff (rst_i)
      !ie_q[aisb_pkg::IE_GLOBAL] |=> !comp_irq_o && !keypad_irq_o && !brownout_irq_o
      && src_q == 7'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt passed closed gate");

  property p_bo_mode;
    @(posedge clk_i) disable iff (rst_i)
      bo_hit |=> (brownout_reset_o != $past(aux_q[aisb_pkg::AUX_BROWNOUT_IRQ]));
  endproperty
  a_bo_mode: assert property (p_bo_mode) else $error("brownout mode wrong");

  property p_duty;
    @(posedge clk_i) disable iff (rst_i)
      duty_mode && duty_q == 4'h1 |=> !detect_on_q;
  endproperty
  a_duty: assert property (p_duty) else $error("duty detector on");

  // Flag stays clear while no enabled pin is low and software writes no 1
  property p_key_masked;
    @(posedge clk_i) disable iff (rst_i)
      !aux_q[aisb_pkg::AUX_KEYPAD_FLAG] && !key_event
      && !(aux_wr && wbyte[aisb_pkg::AUX_KEYPAD_FLAG])
      |=> !aux_q[aisb_pkg::AUX_KEYPAD_FLAG];
  endproperty
  a_key_masked: assert property (p_key_masked) else $error("keypad flag set without pin");

  property p_pin_drive;
    @(posedge clk_i) disable iff (rst_i)
      cmp_en && cmp_q[aisb_pkg::CMP_PIN_DRV] |=> !comp_pin_oe_n_o;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("comparator pin not driven");

  property p_rc_osc;
    @(posedge clk_i) disable iff (rst_i)
      duty_mode |=> rc_osc_enable_o;
  endproperty
  a_rc_osc: assert property (p_rc_osc) else $error("rc oscillator off in duty mode");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      req |=> (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o && !wb_err_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");

  c_key:  cover property (@(posedge clk_i) disable iff (rst_i) keypad_irq_o);
  c_cmp:  cover property (@(posedge clk_i) disable iff (rst_i) comp_irq_o);
  c_duty: cover property (@(posedge clk_i) disable iff (rst_i) rc_on_q && detect_on_q);
  c_soft_chip_reset: cover property (@(posedge clk_i) disable iff (rst_i) chip_reset_o);
endmodule // aisb_bank

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [3:0]  lane = 4'h1;
  logic [7:0]  adrs [5] = '{8'ha1, 8'ha2, 8'ha8, 8'ha9, 8'hac};
  logic [7:0]  port0_pins_i = 8'hff;
  logic        comp_raw_i = 1'b0;
  logic        brownout_flag_i = 1'b0;
  logic        power_down_i = 1'b0;
  logic [6:0]  irq_sources_i = 7'h00;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, wb_err_o, comp_enable_o, comp_pos_select_o, comp_neg_select_o;
  logic        comp_pin_o, comp_pin_oe_n_o, comp_irq_o, keypad_irq_o, brownout_detect_on_o;
  logic        brownout_irq_o, brownout_reset_o, rc_osc_enable_o, chip_reset_o;
  logic        adc_power_on_o, pointer_select_o;
  logic [7:0]  irq_enable_o, serial_node_address_o, rd;
  logic        err_seen;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;
  int          resets_seen = 0;
  int          n;

  always #25 clk_i = ~clk_i;

  aisb_bank u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .port0_pins_i(port0_pins_i), .comp_raw_i(comp_raw_i), .brownout_flag_i(brownout_flag_i),
    .power_down_i(power_down_i), .irq_sources_i(irq_sources_i),
    .comp_enable_o(comp_enable_o), .comp_pos_select_o(comp_pos_select_o),
    .comp_neg_select_o(comp_neg_select_o), .comp_pin_o(comp_pin_o),
    .comp_pin_oe_n_o(comp_pin_oe_n_o), .comp_irq_o(comp_irq_o), .keypad_irq_o(keypad_irq_o),
    .brownout_detect_on_o(brownout_detect_on_o), .brownout_irq_o(brownout_irq_o),
    .brownout_reset_o(brownout_reset_o), .rc_osc_enable_o(rc_osc_enable_o),
    .chip_reset_o(chip_reset_o), .adc_power_on_o(adc_power_on_o),
    .pointer_select_o(pointer_select_o), .irq_enable_o(irq_enable_o),
    .serial_node_address_o(serial_node_address_o)
  );

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (chip_reset_o === 1'b1) begin
      resets_seen++;
    end
    if (cycles == 6000) begin
      mismatches++;
      $display("BAD cycle_limit expected below 6000 seen %0d", cycles);
      close_out();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single cycle; caller enters just after a rising edge
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= lane;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
    rd = wb_dat_o[7:0];
    err_seen = wb_err_o;
    if (k >= 20) begin
      chk("bus_answer", 8'h01, 8'h00);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    bus(1'b1, adr, d);
  endtask

  task automatic rchk(input string name, input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00);
    chk(name, exp, rd);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (adrs[i]) rchk("reset_value", adrs[i], 8'h00);
    chk("oe_n_reset", 8'h01, {7'h0, comp_pin_oe_n_o});
    wr(8'ha1, 8'ha5);
    wr(8'ha8, 8'h5a);
    wr(8'ha9, 8'hc3);
    rchk("keypad_enable", 8'ha1, 8'ha5);
    rchk("irq_mask", 8'ha8, 8'h5a);
    rchk("node_addr", 8'ha9, 8'hc3);
    chk("irq_enable_o", 8'h5a, irq_enable_o);
    chk("node_addr_o", 8'hc3, serial_node_address_o);
    // Write with byte lane 0 off must leave the register alone
    lane = 4'h0;
    wr(8'ha9, 8'h11);
    lane = 4'h1;
    rchk("sel_lane_off", 8'ha9, 8'hc3);
    bus(1'b0, 8'ha3, 8'h00);
    chk("unmapped_err", 8'h01, {7'h0, err_seen});
    // Gated pending status
    irq_sources_i <= 7'h7f;
    wr(8'ha8, 8'h81);
    rchk("status_gate_on", 8'hb0, 8'h01);
    wr(8'ha8, 8'h01);
    rchk("status_gate_off", 8'hb0, 8'h00);
    // Keypad flag: only enabled pins count, hardware set wins, no auto clear
    wr(8'ha1, 8'h05);
    port0_pins_i <= 8'hdf;
    idle(4);
    rchk("kp_masked_pin", 8'ha2, 8'h00);
    port0_pins_i <= 8'hfe;
    idle(4);
    rchk("kp_flag_set", 8'ha2, 8'h80);
    wr(8'ha2, 8'h00);
    rchk("kp_set_wins", 8'ha2, 8'h80);
    port0_pins_i <= 8'hff;
    idle(6);
    rchk("kp_flag_holds", 8'ha2, 8'h80);
    wr(8'ha8, 8'h80);
    chk("kp_irq_gated", 8'h01, {7'h0, keypad_irq_o});
    wr(8'ha2, 8'h00);
    rchk("kp_flag_clear", 8'ha2, 8'h00);
    chk("kp_irq_off", 8'h00, {7'h0, keypad_irq_o});
    // Aux field outputs
    wr(8'ha2, 8'h57);
    rchk("aux_readback", 8'ha2, 8'h55);
    chk("aux_outs", 8'h03, {6'h0, adc_power_on_o, pointer_select_o});
    chk("bod_off", 8'h00, {7'h0, brownout_detect_on_o});
    wr(8'ha8, 8'ha0);
    brownout_flag_i <= 1'b1;
    wr(8'ha2, 8'h20);
    idle(2);
    chk("bo_irq_mode", 8'h02, {6'h0, brownout_irq_o, brownout_reset_o});
    wr(8'ha2, 8'h00);
    idle(2);
    chk("bo_reset_mode", 8'h01, {6'h0, brownout_irq_o, brownout_reset_o});
    brownout_flag_i <= 1'b0;
    power_down_i <= 1'b1;
    idle(3);
    chk("bod_always_on", 8'h01, {7'h0, brownout_detect_on_o});
    wr(8'ha2, 8'h10);
    idle(2);
    chk("rc_osc_on", 8'h01, {7'h0, rc_osc_enable_o});
    n = 0;
    repeat (32) begin
      @(posedge clk_i);
      if (brownout_detect_on_o === 1'b1) n++;
    end
    chk("duty_on_count", 8'h02, n[7:0]);
    power_down_i <= 1'b0;
    n = resets_seen;
    wr(8'ha2, 8'h08);
    idle(4);
    chk("soft_reset_pulses", 8'h01, 8'(resets_seen - n));
    // Comparator one
    wr(8'ha8, 8'h80);
    wr(8'hac, 8'h3c);
    chk("cmp_ctrl_outs", 8'h0e,
        {4'h0, comp_enable_o, comp_pos_select_o, comp_neg_select_o, comp_pin_oe_n_o});
    // Settling time of 10 us before the result is relied on
    idle(200);
    comp_raw_i <= 1'b1;
    idle(4);
    chk("cmp_pin", 8'h01, {7'h0, comp_pin_o});
    rchk("cmp_rise", 8'hac, 8'h3f);
    wr(8'hac, 8'h3c);
    rchk("cmp_flag_clear", 8'hac, 8'h3e);
    comp_raw_i <= 1'b0;
    idle(4);
    rchk("cmp_fall", 8'hac, 8'h3d);
    chk("cmp_irq", 8'h01, {7'h0, comp_irq_o});
    wr(8'hac, 8'h1c);
    rchk("cmp_disabled", 8'hac, 8'h1c);
    chk("cmp_oe_n_off", 8'h01, {7'h0, comp_pin_oe_n_o});
    // Second reset in mid-run
    wr(8'hac, 8'h3c);
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk("rerun_node_addr", 8'ha9, 8'h00);
    rchk("rerun_cmp", 8'hac, 8'h00);
    chk("oe_n_rerun", 8'h01, {7'h0, comp_pin_oe_n_o});
    close_out();
  end
endmodule // tb
